// ==== inc/ibc_pkg.sv ====
// Notes on behaviour
// RQ1: Firmware bits 0-10 gate TCP port filters by the firmware IPv4 match.
// RQ2: Firmware bit 12 gates the UDP port 0 filter by firmware IPv4 match.
// RQ3: Firmware bits 14 and 15 gate the EAP-over-UDP and DNS filters.
// RQ4: Firmware bits 16-27 gate flexible filters 0-11 in order.
// RQ5: Firmware bit 28 gates the port-range filter by firmware IPv4 match.
// RQ6: Firmware bit 29 gates the ICMPv4 filter by firmware IPv4 match.
// RQ7: Firmware bit 30 gates ARP requests only; responses stay unqualified.
// RQ8: Bit 31 in both registers gates RMCP by the host IPv4 match.
// RQ9: Host bits 0-10 gate TCP port filters by the host IPv4 match.
// RQ10: Host bits 12, 14, 15 gate UDP port 0, EAP-over-UDP, DNS filters.
// RQ11: Host bits 16-27 gate flexible filters 0-11 in order.
// RQ12: Host bits 28 and 29 gate port-range and ICMPv4 filters.
// RQ13: Host bit 30 gates both ARP requests and responses by host match.
// RQ14: A clear binding bit, the reset value, leaves its filter unqualified.
// RQ15: Bits 11 and 13 are reserved, read zero and ignore writes.
package ibc_pkg;
    localparam logic [4:0] PHY_ADDR = 5'h01;
    localparam logic [11:0] BIND_PAGE = 12'h321;
    localparam logic [5:0] FW_BIND_REG = 6'h28;
    localparam logic [5:0] HOST_BIND_REG = 6'h2A;
    localparam logic [31:0] BIND_RESET = 32'h0000_0000;
    localparam logic [31:0] BIND_WR_MASK = 32'hFFFF_D7FF;
    localparam int TCP_LO = 0;
    localparam int TCP_HI = 10;
    localparam int UDP0_BIT = 12;
    localparam int EAP_BIT = 14;
    localparam int DNS_BIT = 15;
    localparam int FLEX_LO = 16;
    localparam int FLEX_HI = 27;
    localparam int RANGE_BIT = 28;
    localparam int ICMP_BIT = 29;
    localparam int ARP_BIT = 30;
    localparam int RMCP_BIT = 31;
endpackage : ibc_pkg

// ==== src/ibc_qualify.sv ====
`timescale 1ns/1ps
`default_nettype none
module ibc_qualify
    import ibc_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic [31:0] hit, // Raw filter hits by bit position
    input wire logic [31:0] bind_en, // Binding enables
    input wire logic [31:0] ip_ok, // Address match per position
    output logic [31:0] pass_q // Qualified hits, registered
);
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    pass_q[i] <= 1'b0;
                end else begin
                    // Reserved positions carry no filter at all
                    pass_q[i] <= BIND_WR_MASK[i] & hit[i]
                        & (~bind_en[i] | ip_ok[i]); // [RQ14]
                end
            end
        end
    endgenerate
endmodule : ibc_qualify
`default_nettype wire

// ==== src/ibc_bind_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module ibc_bind_ctrl
    import ibc_pkg::*;
(
    input wire logic core_clk, // 10 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [4:0] reg_phy, // PHY address of access
    input wire logic [11:0] reg_page, // Selected page
    input wire logic [5:0] reg_num, // Register number on the page
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [15:0] reg_wdata, // Write data
    output logic [15:0] reg_rdata, // Read data, one cycle after reg_rd
    input wire logic [31:0] filt_hit, // Raw filter hits by bit position
    input wire logic arp_is_resp, // ARP hit is a response
    input wire logic fw_ip_match, // Firmware IPv4 address matched
    input wire logic host_ip_match, // A host IPv4 address matched
    output logic [31:0] fw_pass, // Firmware-path qualified hits
    output logic [31:0] host_pass, // Host-path qualified hits
    output logic [31:0] fw_bind, // Firmware binding register
    output logic [31:0] host_bind // Host binding register
);
    logic [31:0] fw_bind_q;
    logic [31:0] host_bind_q;
    logic [15:0] rdata_q;
    logic [31:0] fw_ok;
    logic [31:0] host_ok;
    logic sel_ok;
    logic num_hit;

    // Register numbers 40..43: low half at even, high half at odd
    function automatic logic hit_reg(input logic [5:0] num,
                                     input logic [5:0] base,
                                     input logic odd);
        hit_reg = num == (base | {5'h00, odd});
    endfunction : hit_reg

    assign sel_ok = reg_phy == PHY_ADDR && reg_page == BIND_PAGE;

    // Any of the four mapped numbers, so the checks can spot refused access
    assign num_hit = hit_reg(reg_num, FW_BIND_REG, 1'b0)
        || hit_reg(reg_num, FW_BIND_REG, 1'b1)
        || hit_reg(reg_num, HOST_BIND_REG, 1'b0)
        || hit_reg(reg_num, HOST_BIND_REG, 1'b1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fw_bind_q <= BIND_RESET; // [RQ14]
        end else if (reg_wr && sel_ok) begin
            if (hit_reg(reg_num, FW_BIND_REG, 1'b0)) begin
                fw_bind_q[15:0] <= reg_wdata & BIND_WR_MASK[15:0]; // [RQ15]
            end else if (hit_reg(reg_num, FW_BIND_REG, 1'b1)) begin
                fw_bind_q[31:16] <= reg_wdata & BIND_WR_MASK[31:16];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            host_bind_q <= BIND_RESET; // [RQ14]
        end else if (reg_wr && sel_ok) begin
            if (hit_reg(reg_num, HOST_BIND_REG, 1'b0)) begin
                host_bind_q[15:0] <= reg_wdata & BIND_WR_MASK[15:0]; // [RQ15]
            end else if (hit_reg(reg_num, HOST_BIND_REG, 1'b1)) begin
                host_bind_q[31:16] <= reg_wdata & BIND_WR_MASK[31:16];
            end
        end
    end

    // Unmapped numbers read zero so a stray poll never sees stale data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            if (sel_ok && hit_reg(reg_num, FW_BIND_REG, 1'b0)) begin
                rdata_q <= fw_bind_q[15:0];
            end else if (sel_ok && hit_reg(reg_num, FW_BIND_REG, 1'b1)) begin
                rdata_q <= fw_bind_q[31:16];
            end else if (sel_ok && hit_reg(reg_num, HOST_BIND_REG, 1'b0)) begin
                rdata_q <= host_bind_q[15:0];
            end else if (sel_ok && hit_reg(reg_num, HOST_BIND_REG, 1'b1)) begin
                rdata_q <= host_bind_q[31:16];
            end else begin
                rdata_q <= 16'h0000;
            end
        end
    end

    always_comb begin
        // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6]
        fw_ok = {32{fw_ip_match}};
        // ARP responses are outside the firmware binding
        fw_ok[ARP_BIT] = fw_ip_match | arp_is_resp; // [RQ7]
        // RMCP is qualified by the host addresses even here
        fw_ok[RMCP_BIT] = host_ip_match; // [RQ8]
        // [RQ9] [RQ10] [RQ11] [RQ12] [RQ13]
        host_ok = {32{host_ip_match}};
    end

    ibc_qualify u_fw_qual (
        .core_clk(core_clk),
        .rst(rst),
        .hit(filt_hit),
        .bind_en(fw_bind_q),
        .ip_ok(fw_ok),
        .pass_q(fw_pass)
    );

    ibc_qualify u_host_qual (
        .core_clk(core_clk),
        .rst(rst),
        .hit(filt_hit),
        .bind_en(host_bind_q),
        .ip_ok(host_ok),
        .pass_q(host_pass)
    );

    assign reg_rdata = rdata_q;
    assign fw_bind = fw_bind_q;
    assign host_bind = host_bind_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_fw_lo_write;
        reg_wr && sel_ok && reg_num == FW_BIND_REG;
    endsequence

    sequence s_fw_hi_write;
        reg_wr && sel_ok && reg_num == (FW_BIND_REG | 6'h01);
    endsequence

    sequence s_host_lo_write;
        reg_wr && sel_ok && reg_num == HOST_BIND_REG;
    endsequence

    sequence s_host_hi_write;
        reg_wr && sel_ok && reg_num == (HOST_BIND_REG | 6'h01);
    endsequence

    sequence s_refused_write;
        reg_wr && !(sel_ok && num_hit);
    endsequence

    property p_block(int b, logic [31:0] bv, logic ok, logic [31:0] pv);
        filt_hit[b] && bv[b] && !ok |=> !pv[b];
    endproperty

    property p_pass(int b, logic [31:0] bv, logic ok, logic [31:0] pv);
        filt_hit[b] && (!bv[b] || ok) |=> pv[b];
    endproperty

    a_reserved_zero: assert property ( // [RQ15]
        !fw_bind_q[11] && !fw_bind_q[13] && !host_bind_q[11]
        && !host_bind_q[13])
        else $error("reserved binding bit set");
    a_fw_lo_write: assert property ( // [RQ1]
        s_fw_lo_write |=> fw_bind_q[15:0]
            == ($past(reg_wdata) & BIND_WR_MASK[15:0]))
        else $error("firmware low half write lost");
    a_fw_tcp_block: assert property ( // [RQ1]
        p_block(TCP_HI, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware tcp hit passed without match");
    a_fw_udp_block: assert property ( // [RQ2]
        p_block(UDP0_BIT, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware udp hit passed without match");
    a_fw_dns_block: assert property ( // [RQ3]
        p_block(DNS_BIT, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware dns hit passed without match");
    a_fw_flex_block: assert property ( // [RQ4]
        p_block(FLEX_HI, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware flex hit passed without match");
    a_fw_icmp_block: assert property ( // [RQ6]
        p_block(ICMP_BIT, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware icmp hit passed without match");
    a_fw_arp_resp: assert property ( // [RQ7]
        filt_hit[ARP_BIT] && arp_is_resp |=> fw_pass[ARP_BIT])
        else $error("firmware arp response was blocked");
    a_fw_rmcp_host: assert property ( // [RQ8]
        filt_hit[RMCP_BIT] && host_ip_match && !fw_ip_match
        |=> fw_pass[RMCP_BIT])
        else $error("firmware rmcp ignored host match");
    a_host_arp_gate: assert property ( // [RQ13]
        filt_hit[ARP_BIT] && host_bind_q[ARP_BIT] && arp_is_resp
        && !host_ip_match |=> !host_pass[ARP_BIT])
        else $error("host arp response passed without match");
    a_host_range_gate: assert property ( // [RQ12]
        p_block(RANGE_BIT, host_bind_q, host_ip_match, host_pass))
        else $error("host range hit passed without match");
    a_unbound_pass: assert property ( // [RQ14]
        filt_hit[EAP_BIT] && !host_bind_q[EAP_BIT]
        |=> host_pass[EAP_BIT])
        else $error("unbound filter hit was dropped");
    a_read_one_cycle: assert property ( // [RQ15]
        reg_rd && sel_ok && reg_num == FW_BIND_REG
        |=> reg_rdata == $past(fw_bind_q[15:0]))
        else $error("read data wrong");
    a_fw_hi_write: assert property ( // [RQ4]
        s_fw_hi_write |=> fw_bind_q[31:16]
            == ($past(reg_wdata) & BIND_WR_MASK[31:16]))
        else $error("firmware high half write lost");
    a_host_lo_write: assert property ( // [RQ9]
        s_host_lo_write |=> host_bind_q[15:0]
            == ($past(reg_wdata) & BIND_WR_MASK[15:0]))
        else $error("host low half write lost");
    a_host_hi_write: assert property ( // [RQ11]
        s_host_hi_write |=> host_bind_q[31:16]
            == ($past(reg_wdata) & BIND_WR_MASK[31:16]))
        else $error("host high half write lost");
    a_refused_write: assert property ( // [RQ14]
        s_refused_write |=> $stable(fw_bind_q) && $stable(host_bind_q))
        else $error("refused write changed a binding register");
    a_unmapped_read: assert property ( // [RQ15]
        reg_rd && !(sel_ok && num_hit) |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");
    a_fw_tcp0_block: assert property ( // [RQ1]
        p_block(TCP_LO, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware tcp 0 hit passed without match");
    a_fw_eap_block: assert property ( // [RQ3]
        p_block(EAP_BIT, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware eap hit passed without match");
    a_fw_range_block: assert property ( // [RQ5]
        p_block(RANGE_BIT, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware range hit passed without match");
    a_fw_arp_req: assert property ( // [RQ7]
        filt_hit[ARP_BIT] && fw_bind_q[ARP_BIT] && !arp_is_resp
        && !fw_ip_match |=> !fw_pass[ARP_BIT])
        else $error("firmware arp request passed without match");
    a_fw_rmcp_block: assert property ( // [RQ8]
        p_block(RMCP_BIT, fw_bind_q, host_ip_match, fw_pass))
        else $error("firmware rmcp hit passed without host match");
    a_fw_bound_pass: assert property ( // [RQ6]
        p_pass(ICMP_BIT, fw_bind_q, fw_ip_match, fw_pass))
        else $error("firmware icmp hit was dropped");
    a_host_tcp_block: assert property ( // [RQ9]
        p_block(TCP_LO, host_bind_q, host_ip_match, host_pass))
        else $error("host tcp hit passed without match");
    a_host_udp_block: assert property ( // [RQ10]
        p_block(UDP0_BIT, host_bind_q, host_ip_match, host_pass))
        else $error("host udp hit passed without match");
    a_host_flex_block: assert property ( // [RQ11]
        p_block(FLEX_LO, host_bind_q, host_ip_match, host_pass))
        else $error("host flex hit passed without match");
    a_host_icmp_block: assert property ( // [RQ12]
        p_block(ICMP_BIT, host_bind_q, host_ip_match, host_pass))
        else $error("host icmp hit passed without match");
    a_host_rmcp_block: assert property ( // [RQ8]
        p_block(RMCP_BIT, host_bind_q, host_ip_match, host_pass))
        else $error("host rmcp hit passed without match");
    a_host_bound_pass: assert property ( // [RQ13]
        p_pass(ARP_BIT, host_bind_q, host_ip_match, host_pass))
        else $error("host arp hit was dropped");
    a_reserved_pass: assert property ( // [RQ15]
        (fw_pass & ~BIND_WR_MASK) == 32'h0000_0000
        && (host_pass & ~BIND_WR_MASK) == 32'h0000_0000)
        else $error("reserved filter position passed a hit");
    a_reset_clear: assert property ( // [RQ14]
        disable iff (1'b0)
        rst |=> fw_bind_q == BIND_RESET && host_bind_q == BIND_RESET
            && fw_pass == 32'h0000_0000 && host_pass == 32'h0000_0000
            && reg_rdata == 16'h0000)
        else $error("reset left state behind");
endmodule : ibc_bind_ctrl
`default_nettype wire

// ==== bench/ibc_mac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ibc_mac_model
    import ibc_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic [15:0] reg_rdata, // Read data
    output logic [4:0] reg_phy, // PHY address
    output logic [11:0] reg_page, // Page
    output logic [5:0] reg_num, // Register number
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [15:0] reg_wdata // Write data
);
    initial begin
        reg_phy = PHY_ADDR;
        reg_page = 12'h000;
        reg_num = 6'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end

    task automatic access(input logic [4:0] phy, input logic [11:0] pg,
            input logic [5:0] num, input logic wr, input logic [15:0] wd,
            output logic [15:0] rd);
        @(posedge core_clk);
        reg_phy <= phy;
        reg_page <= pg;
        reg_num <= num;
        reg_wdata <= wd;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // Released data flips so a stale value never looks valid
        reg_wdata <= ~wd;
        @(posedge core_clk);
        rd = reg_rdata;
    endtask : access
endmodule : ibc_mac_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
    import ibc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] filt_hit = 32'h0;
    logic arp_is_resp = 1'b0;
    logic fw_ip_match = 1'b0;
    logic host_ip_match = 1'b0;
    logic [4:0] reg_phy;
    logic [11:0] reg_page;
    logic [5:0] reg_num;
    logic reg_wr, reg_rd;
    logic [15:0] reg_wdata, reg_rdata;
    logic [31:0] fw_pass, host_pass, fw_bind, host_bind;
    int failures = 0;
    int tests_run = 0;

    always #50 core_clk = ~core_clk;

    ibc_mac_model mac(.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_phy(reg_phy), .reg_page(reg_page), .reg_num(reg_num),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    ibc_bind_ctrl uut(.core_clk(core_clk), .rst(rst), .reg_phy(reg_phy),
        .reg_page(reg_page), .reg_num(reg_num), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .filt_hit(filt_hit), .arp_is_resp(arp_is_resp),
        .fw_ip_match(fw_ip_match), .host_ip_match(host_ip_match),
        .fw_pass(fw_pass), .host_pass(host_pass), .fw_bind(fw_bind),
        .host_bind(host_bind));

    task automatic check_val(input logic [31:0] got, input logic [31:0] ex);
        tests_run++;
        if (got !== ex) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, ex);
        end
    endtask : check_val

    task automatic rd_chk(input logic [5:0] num, input logic [15:0] ex);
        logic [15:0] d;
        mac.access(PHY_ADDR, BIND_PAGE, num, 1'b0, 16'h0000, d);
        check_val({16'h0000, d}, {16'h0000, ex});
    endtask : rd_chk

    // m[0] firmware match, m[1] host match, m[2] ARP response
    function automatic logic [31:0] exp_pass(input logic fw,
            input logic [31:0] bnd, input int b, input logic [2:0] m);
        logic ok;
        ok = fw ? m[0] : m[1];
        if (fw && b == ARP_BIT)
            ok = m[0] | m[2];
        if (fw && b == RMCP_BIT)
            ok = m[1];
        exp_pass = 32'h0;
        exp_pass[b] = (!bnd[b] | ok) && b != 11 && b != 13;
    endfunction : exp_pass

    task automatic test_program(input logic [31:0] fw, input logic [31:0] h);
        logic [15:0] d;
        mac.access(PHY_ADDR, BIND_PAGE, 6'h28, 1'b1, fw[15:0], d);
        mac.access(PHY_ADDR, BIND_PAGE, 6'h29, 1'b1, fw[31:16], d);
        mac.access(PHY_ADDR, BIND_PAGE, 6'h2A, 1'b1, h[15:0], d);
        mac.access(PHY_ADDR, BIND_PAGE, 6'h2B, 1'b1, h[31:16], d);
        fw = fw & BIND_WR_MASK;
        h = h & BIND_WR_MASK;
        rd_chk(6'h28, fw[15:0]);
        rd_chk(6'h29, fw[31:16]);
        rd_chk(6'h2A, h[15:0]);
        rd_chk(6'h2B, h[31:16]);
        check_val(fw_bind, fw);
        check_val(host_bind, h);
    endtask : test_program

    task automatic test_filters(input logic [31:0] fw, input logic [31:0] h);
        for (int b = 0; b < 32; b++) begin
            for (int m = 0; m < 8; m++) begin
                @(posedge core_clk);
                filt_hit <= 32'h1 << b;
                fw_ip_match <= m[0];
                host_ip_match <= m[1];
                arp_is_resp <= m[2];
                @(posedge core_clk);
                @(negedge core_clk);
                check_val(fw_pass, exp_pass(1'b1, fw, b, m[2:0]));
                check_val(host_pass, exp_pass(1'b0, h, b, m[2:0]));
            end
        end
    endtask : test_filters

    task automatic test_refused;
        logic [15:0] d;
        mac.access(PHY_ADDR, BIND_PAGE + 12'h001, 6'h28, 1'b1, 16'h1234, d);
        mac.access(PHY_ADDR + 5'h01, BIND_PAGE, 6'h2A, 1'b1, 16'h1234, d);
        mac.access(PHY_ADDR, BIND_PAGE, 6'h2C, 1'b1, 16'h1234, d);
        mac.access(PHY_ADDR + 5'h01, BIND_PAGE, 6'h28, 1'b0, 16'h0000, d);
        check_val({16'h0000, d}, 32'h0000_0000);
        rd_chk(6'h2C, 16'h0000);
        check_val(fw_bind, BIND_WR_MASK);
        check_val(host_bind, BIND_WR_MASK);
    endtask : test_refused

    task automatic test_reset_state;
        for (int n = 40; n < 44; n++)
            rd_chk(n[5:0], 16'h0000);
        check_val(fw_bind | host_bind, BIND_RESET);
    endtask : test_reset_state

    task automatic test_done;
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        test_reset_state;
        test_filters(32'h0, 32'h0);
        test_program(32'hA5C3_5AF0, 32'h5A3C_A50F);
        test_filters(32'hA5C3_5AF0 & BIND_WR_MASK,
            32'h5A3C_A50F & BIND_WR_MASK);
        test_program(32'hFFFF_FFFF, 32'hFFFF_FFFF);
        test_filters(BIND_WR_MASK, BIND_WR_MASK);
        test_refused;
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        test_reset_state;
        test_done;
    end

    initial begin
        #1000000;
        failures++;
        test_done;
    end
endmodule : tb
`default_nettype wire
